// ==== common/mfd_pkg.sv ====
package mfd_pkg;

    // Register byte offsets, one aligned word each
    localparam logic [7:0] SYS_CTRL_OFS   = 8'h00;
    localparam logic [7:0] MODE_OFS       = 8'h04;
    localparam logic [7:0] PTR_OFS        = 8'h08;
    localparam logic [7:0] NEXT_MODE_OFS  = 8'h0C;
    localparam logic [7:0] NEXT_PTR_OFS   = 8'h10;

    // System control fields
    localparam int SC_MASTER_EN_BIT = 0;
    localparam int SC_LOOP_LSB      = 1;
    localparam int SC_SYNC_SEL_BIT  = 3;

    // Loopback level codes that allow dispatching
    localparam logic [1:0] LOOP_FULL     = 2'h3;
    localparam logic [1:0] LOOP_INTERNAL = 2'h2;

    // Dispatch mode fields (low halfword also used by the advance copy)
    localparam int MODE_MANUAL_BIT = 0;
    localparam int MODE_AUTO_BIT   = 1;
    localparam int MODE_TIMED_BIT  = 2;
    localparam int MODE_EMPTY_BIT  = 3;
    localparam int MODE_LEN_LSB    = 4;
    localparam int MODE_LEN_MSB    = 8;
    localparam int MODE_CANCEL_BIT = 16;
    localparam int MODE_BUSY_BIT   = 17;

    // Table length: a zero field means a full table
    localparam logic [5:0] TABLE_FULL_LEN = 6'h20;
    localparam logic [5:0] LEFT_LAST      = 6'h01;

    // Memory layout
    localparam logic [15:0] FRAME_SLOT_ADDR = 16'h0000;
    localparam logic [15:0] TABLE_STEP      = 16'h0002;
    localparam logic [15:0] PTR_MASK        = 16'hFFFC;

    // Spacing between a slave frame and the next master frame
    localparam int CLK_PERIOD_NS = 10;
    localparam int GAP_NS        = 4000;
    localparam logic [8:0] GAP_CYC = 9'((GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_SEND,
        ST_WAIT_TEL
    } disp_state_t;

    typedef struct packed {
        logic        rd;
        logic [15:0] addr;
    } mem_req_t;

    typedef struct packed {
        logic        start;
        logic [15:0] frame;
    } tx_req_t;

    typedef struct packed {
        logic        done;
        logic        timeout;
    } tel_status_t;

endpackage

// ==== logic/master_frame_dispatcher.sv ====
// Functional notes
// R01 - No frame sent until master enable set and loopback level is full or internal.
// R02 - Clearing master enable only suspends; pending requests resume when set again.
// R03 - Writing one to cancel bit drops current dispatch requests, per mechanism limits.
// R04 - Table done pulses once the addressed table of auto, timed or empty completes.
// R05 - Manual frames wait while a table or its chained advance table runs.
// R06 - Manual frame needs no queued table, busy clear, and 4 us since slave frame.
// R07 - Host writes frame slot first, then sets the manual request.
// R08 - After reading the frame slot the frame fetched event pulses.
// R09 - Busy rises at once on manual dispatch, falls at telegram end or timeout.
// R10 - Reply checked pulses with end of busy, but not on reply timeout.
// R11 - Host writes a 16-bit table pointer with two low bits zero first.
// R12 - Table request and 5-bit length written together; zero length means 32.
// R13 - Automatic table starts only with busy clear and frame spacing reached.
// R14 - Frame fetched per table entry, table done at last entry, busy until telegram end.
// R15 - Timed request waits for timer one zero; busy rises at first transmitted frame.
// R16 - Empty table sends nothing; on timer zero it raises table done immediately.
// R17 - On table done the advance mode and pointer copy into the primary registers.
// R18 - Advance mode cleared after copy; copy ORs into pending requests; no control half.
// R19 - Manual request cancelled only before the frame slot read starts.
// R20 - Cancelled automatic table finishes its current telegram, then stops.
// R21 - Timed and empty requests fully cancellable until the timer reaches zero.
// R22 - Timed and empty start may come from the external sync input instead.
`timescale 1ns/1ps
module master_frame_dispatcher (
    input  wire  logic                 I_MCLK,
    input  wire  logic                 I_RST_B,
    input  wire  logic [7:0]           I_ADDR,
    input  wire  logic [31:0]          I_WDATA,
    input  wire  logic                 I_WR,
    input  wire  logic                 I_RD,
    output logic       [31:0]          O_RDATA,
    output mfd_pkg::mem_req_t          O_MEM,
    input  wire  logic                 I_MEM_ACK,
    input  wire  logic [15:0]          I_MEM_DATA,
    output mfd_pkg::tx_req_t           O_TX,
    input  wire  mfd_pkg::tel_status_t I_TEL,
    input  wire  logic                 I_TIMER1_ZERO,
    input  wire  logic                 I_EXT_SYNC_B,
    output logic                       O_BUSY,
    output logic                       O_TABLE_DONE_IRQ,
    output logic                       O_FRAME_FETCHED_IRQ,
    output logic                       O_REPLY_CHECKED_IRQ
);

    mfd_pkg::disp_state_t state_reg;
    logic        master_en_reg;
    logic [1:0]  loop_level_reg;
    logic        sync_sel_reg;
    logic        req_manual_reg;
    logic        req_auto_reg;
    logic        req_timed_reg;
    logic        req_empty_reg;
    logic [4:0]  tbl_len_reg;
    logic [15:0] tbl_ptr_reg;
    logic [8:0]  next_mode_reg;
    logic [15:0] next_ptr_reg;
    logic        fired_reg;
    logic        tbl_run_reg;
    logic        cur_manual_reg;
    logic [5:0]  left_reg;
    logic [15:0] fetch_addr_reg;
    logic [15:0] frame_reg;
    logic [8:0]  gap_cnt_reg;
    logic        sync_ff1_reg;
    logic        sync_ff2_reg;
    logic        sync_old_reg;

    logic        run_ok;
    logic        gap_ok;
    logic        table_ready;
    logic        can_start;
    logic        start_tbl;
    logic        start_man;
    logic        cont_tbl;
    logic        fetch_done;
    logic        last_fetch;
    logic        timer_evt;
    logic        empty_done;
    logic        handover;
    logic        cancel;
    logic        wr_mode;
    logic [8:0]  cum_mode;

    // R01 dispatch prerequisite
    assign run_ok = master_en_reg
                    && (loop_level_reg == mfd_pkg::LOOP_FULL || loop_level_reg == mfd_pkg::LOOP_INTERNAL);
    assign gap_ok      = (gap_cnt_reg >= mfd_pkg::GAP_CYC);
    assign table_ready = req_auto_reg | fired_reg;
    // R13 busy clear and spacing reached
    assign can_start   = (state_reg == mfd_pkg::ST_IDLE) && run_ok && !O_BUSY && gap_ok;
    assign start_tbl   = can_start && !tbl_run_reg && table_ready;
    // R05 table before manual
    // R06 manual start conditions
    assign start_man   = can_start && !tbl_run_reg && !table_ready && req_manual_reg;
    assign cont_tbl    = can_start && tbl_run_reg;
    assign fetch_done  = (state_reg == mfd_pkg::ST_FETCH) && I_MEM_ACK;
    assign last_fetch  = fetch_done && !cur_manual_reg && (left_reg == mfd_pkg::LEFT_LAST);
    // R22 external sync as timer source
    assign timer_evt   = sync_sel_reg ? (sync_old_reg && !sync_ff2_reg) : I_TIMER1_ZERO;
    // R16 empty table completes on timer
    assign empty_done  = timer_evt && req_empty_reg && !req_timed_reg && !fired_reg;
    // R04 table done sources
    assign handover    = last_fetch || empty_done;
    assign wr_mode     = I_WR && (I_ADDR == mfd_pkg::MODE_OFS);
    // R03 cancel strobe
    assign cancel      = wr_mode && I_WDATA[mfd_pkg::MODE_CANCEL_BIT];
    assign cum_mode    = {tbl_len_reg, req_empty_reg, req_timed_reg, req_auto_reg, req_manual_reg};

    // Pin synchroniser; only the second stage feeds the edge detector
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            sync_ff1_reg <= 1'b1;
            sync_ff2_reg <= 1'b1;
            sync_old_reg <= 1'b1;
        end
        else
        begin
            sync_ff1_reg <= I_EXT_SYNC_B;
            sync_ff2_reg <= sync_ff1_reg;
            sync_old_reg <= sync_ff2_reg;
        end
    end

    // System control register
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            master_en_reg  <= 1'b0;
            loop_level_reg <= 2'h0;
            sync_sel_reg   <= 1'b0;
        end
        else if (I_WR && I_ADDR == mfd_pkg::SYS_CTRL_OFS)
        begin
            // R02 enable only gates dispatch
            master_en_reg  <= I_WDATA[mfd_pkg::SC_MASTER_EN_BIT];
            loop_level_reg <= I_WDATA[mfd_pkg::SC_LOOP_LSB +: 2];
            sync_sel_reg   <= I_WDATA[mfd_pkg::SC_SYNC_SEL_BIT];
        end
    end

    // Primary mode and pointer; hardware updates win over software
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            req_manual_reg <= 1'b0;
            req_auto_reg   <= 1'b0;
            req_timed_reg  <= 1'b0;
            req_empty_reg  <= 1'b0;
            tbl_len_reg    <= 5'h00;
            tbl_ptr_reg    <= 16'h0000;
            fired_reg      <= 1'b0;
        end
        else
        begin
            // R12 request and length in one write
            if (wr_mode && !cancel)
            begin
                req_manual_reg <= I_WDATA[mfd_pkg::MODE_MANUAL_BIT];
                req_auto_reg   <= I_WDATA[mfd_pkg::MODE_AUTO_BIT];
                req_timed_reg  <= I_WDATA[mfd_pkg::MODE_TIMED_BIT];
                req_empty_reg  <= I_WDATA[mfd_pkg::MODE_EMPTY_BIT];
                tbl_len_reg    <= I_WDATA[mfd_pkg::MODE_LEN_MSB:mfd_pkg::MODE_LEN_LSB];
            end
            // R03 cancel drops requests
            // R21 timed and empty dropped before fire
            if (cancel)
            begin
                req_manual_reg <= 1'b0;
                req_auto_reg   <= 1'b0;
                if (!fired_reg)
                begin
                    req_timed_reg <= 1'b0;
                    req_empty_reg <= 1'b0;
                end
            end
            // R11 pointer low bits forced zero
            if (I_WR && I_ADDR == mfd_pkg::PTR_OFS)
                tbl_ptr_reg <= I_WDATA[15:0] & mfd_pkg::PTR_MASK;
            // R15 timed waits for timer zero
            if (timer_evt && req_timed_reg && !fired_reg)
            begin
                fired_reg     <= 1'b1;
                req_timed_reg <= 1'b0;
            end
            if (empty_done)
                req_empty_reg <= 1'b0;
            if (start_tbl)
            begin
                req_auto_reg <= 1'b0;
                if (!req_auto_reg)
                    fired_reg <= 1'b0;
            end
            // R19 manual consumed at slot read start
            if (start_man)
                req_manual_reg <= 1'b0;
            // R17 advance copy on table done
            // R18 cumulative OR of requests
            if (handover)
            begin
                req_manual_reg <= cum_mode[mfd_pkg::MODE_MANUAL_BIT] | next_mode_reg[mfd_pkg::MODE_MANUAL_BIT];
                req_auto_reg   <= (cum_mode[mfd_pkg::MODE_AUTO_BIT] && !start_tbl)
                                  | next_mode_reg[mfd_pkg::MODE_AUTO_BIT];
                req_timed_reg  <= cum_mode[mfd_pkg::MODE_TIMED_BIT] | next_mode_reg[mfd_pkg::MODE_TIMED_BIT];
                req_empty_reg  <= (cum_mode[mfd_pkg::MODE_EMPTY_BIT] && !empty_done)
                                  | next_mode_reg[mfd_pkg::MODE_EMPTY_BIT];
                tbl_len_reg    <= next_mode_reg[mfd_pkg::MODE_LEN_MSB:mfd_pkg::MODE_LEN_LSB];
                tbl_ptr_reg    <= next_ptr_reg;
            end
        end
    end

    // Advance registers; the copy's clear beats a same-cycle write
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            next_mode_reg <= 9'h000;
            next_ptr_reg  <= 16'h0000;
        end
        else
        begin
            if (I_WR && I_ADDR == mfd_pkg::NEXT_MODE_OFS)
                next_mode_reg <= I_WDATA[8:0];
            if (I_WR && I_ADDR == mfd_pkg::NEXT_PTR_OFS)
                next_ptr_reg <= I_WDATA[15:0] & mfd_pkg::PTR_MASK;
            // R18 advance mode cleared
            if (handover)
                next_mode_reg <= 9'h000;
        end
    end

    // Dispatch engine
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            state_reg      <= mfd_pkg::ST_IDLE;
            tbl_run_reg    <= 1'b0;
            cur_manual_reg <= 1'b0;
            left_reg       <= 6'h00;
            fetch_addr_reg <= 16'h0000;
            frame_reg      <= 16'h0000;
            O_MEM          <= '0;
            O_TX           <= '0;
        end
        else
        begin
            O_MEM.rd    <= 1'b0;
            O_TX.start  <= 1'b0;
            // R20 cancelled table stops after current telegram
            if (cancel)
                tbl_run_reg <= 1'b0;
            unique case (state_reg)
                mfd_pkg::ST_IDLE:
                begin
                    if (start_tbl || start_man || (cont_tbl && !cancel))
                    begin
                        state_reg      <= mfd_pkg::ST_FETCH;
                        O_MEM.rd       <= 1'b1;
                        cur_manual_reg <= start_man;
                        // R07 frame slot read for manual
                        if (start_man)
                            O_MEM.addr <= mfd_pkg::FRAME_SLOT_ADDR;
                        else if (start_tbl)
                            O_MEM.addr <= tbl_ptr_reg;
                        else
                            O_MEM.addr <= fetch_addr_reg;
                        if (start_tbl)
                        begin
                            tbl_run_reg    <= !cancel;
                            fetch_addr_reg <= tbl_ptr_reg;
                            // R12 zero length means full table
                            left_reg       <= (tbl_len_reg == 5'h00) ? mfd_pkg::TABLE_FULL_LEN
                                                                     : {1'b0, tbl_len_reg};
                        end
                    end
                end
                mfd_pkg::ST_FETCH:
                begin
                    if (I_MEM_ACK)
                    begin
                        frame_reg <= I_MEM_DATA;
                        state_reg <= mfd_pkg::ST_SEND;
                        if (!cur_manual_reg)
                        begin
                            fetch_addr_reg <= O_MEM.addr + mfd_pkg::TABLE_STEP;
                            left_reg       <= left_reg - 6'h01;
                            // R14 table done at last entry
                            if (left_reg == mfd_pkg::LEFT_LAST)
                                tbl_run_reg <= 1'b0;
                        end
                    end
                end
                mfd_pkg::ST_SEND:
                begin
                    O_TX.start <= 1'b1;
                    O_TX.frame <= frame_reg;
                    state_reg  <= mfd_pkg::ST_WAIT_TEL;
                end
                mfd_pkg::ST_WAIT_TEL:
                begin
                    if (I_TEL.done)
                        state_reg <= mfd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Busy, spacing counter and event pulses
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            O_BUSY              <= 1'b0;
            gap_cnt_reg         <= mfd_pkg::GAP_CYC;
            O_TABLE_DONE_IRQ    <= 1'b0;
            O_FRAME_FETCHED_IRQ <= 1'b0;
            O_REPLY_CHECKED_IRQ <= 1'b0;
        end
        else
        begin
            // R09 busy at once for manual
            // R15 busy at first transmitted table frame
            if (start_man || (state_reg == mfd_pkg::ST_SEND))
                O_BUSY <= 1'b1;
            else if (state_reg == mfd_pkg::ST_WAIT_TEL && I_TEL.done)
                O_BUSY <= 1'b0;
            // R06 slave to master spacing
            if (state_reg == mfd_pkg::ST_WAIT_TEL && I_TEL.done)
                gap_cnt_reg <= 9'h000;
            else if (!gap_ok)
                gap_cnt_reg <= gap_cnt_reg + 9'h001;
            // R08 slot read complete
            O_FRAME_FETCHED_IRQ <= fetch_done;
            // R04 table done pulse
            O_TABLE_DONE_IRQ    <= handover;
            // R10 no reply checked on timeout
            O_REPLY_CHECKED_IRQ <= (state_reg == mfd_pkg::ST_WAIT_TEL) && I_TEL.done && !I_TEL.timeout;
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge I_MCLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            O_RDATA <= 32'h0000_0000;
        else if (I_RD)
        begin
            O_RDATA <= 32'h0000_0000;
            unique case (I_ADDR)
                mfd_pkg::SYS_CTRL_OFS:
                begin
                    O_RDATA[mfd_pkg::SC_MASTER_EN_BIT]    <= master_en_reg;
                    O_RDATA[mfd_pkg::SC_LOOP_LSB +: 2]    <= loop_level_reg;
                    O_RDATA[mfd_pkg::SC_SYNC_SEL_BIT]     <= sync_sel_reg;
                end
                mfd_pkg::MODE_OFS:
                begin
                    O_RDATA[8:0]                          <= cum_mode;
                    O_RDATA[mfd_pkg::MODE_BUSY_BIT]       <= O_BUSY;
                end
                mfd_pkg::PTR_OFS:       O_RDATA[15:0] <= tbl_ptr_reg;
                mfd_pkg::NEXT_MODE_OFS: O_RDATA[8:0]  <= next_mode_reg;
                mfd_pkg::NEXT_PTR_OFS:  O_RDATA[15:0] <= next_ptr_reg;
                default:                O_RDATA       <= 32'h0000_0000;
            endcase
        end
        else
            O_RDATA <= 32'h0000_0000;
    end

endmodule

// ==== sim/mfd_far_model.sv ====
`timescale 1ns/1ps
module mfd_far_model (
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire mfd_pkg::mem_req_t i_mem,
    output logic                   o_ack,
    output logic [15:0]            o_data,
    input  wire mfd_pkg::tx_req_t  i_tx,
    output mfd_pkg::tel_status_t   o_tel,
    input  wire logic              i_slow,
    input  wire logic              i_tmo
);
    logic [2:0]  mem_cnt;
    logic [4:0]  tel_cnt;
    logic [15:0] addr_reg;

    // slot and table words are the read address XOR 16'h5A5A
    always_ff @(posedge i_clk or negedge i_rst_b)
        if (!i_rst_b)
        begin
            mem_cnt  <= 3'h0;
            o_ack    <= 1'b0;
            o_data   <= 16'h0000;
            addr_reg <= 16'h0000;
        end
        else if (i_mem.rd)
        begin
            mem_cnt  <= i_slow ? 3'h6 : 3'h1;
            addr_reg <= i_mem.addr;
            o_ack    <= 1'b0;
            o_data   <= ~o_data;
        end
        else if (mem_cnt == 3'h1)
        begin
            mem_cnt <= 3'h0;
            o_ack   <= 1'b1;
            o_data  <= addr_reg ^ 16'h5A5A;
        end
        else
        begin
            // Idle data toggles so a stale word never looks valid
            mem_cnt <= (mem_cnt == 3'h0) ? 3'h0 : mem_cnt - 3'h1;
            o_ack   <= 1'b0;
            o_data  <= ~o_data;
        end

    always_ff @(posedge i_clk or negedge i_rst_b)
        if (!i_rst_b)
        begin
            tel_cnt <= 5'h00;
            o_tel   <= '0;
        end
        else if (i_tx.start)
        begin
            tel_cnt <= 5'h14;
            o_tel   <= '0;
        end
        else
        begin
            tel_cnt       <= (tel_cnt == 5'h00) ? 5'h00 : tel_cnt - 5'h01;
            o_tel.done    <= (tel_cnt == 5'h01);
            o_tel.timeout <= (tel_cnt == 5'h01) && i_tmo;
        end
endmodule

// ==== sim/mfd_props.sv ====
`timescale 1ns/1ps
module mfd_props (
    input wire logic                 I_MCLK,
    input wire logic                 I_RST_B,
    input wire logic [7:0]           I_ADDR,
    input wire logic [31:0]          I_WDATA,
    input wire logic                 I_WR,
    input wire mfd_pkg::mem_req_t    O_MEM,
    input wire logic                 I_MEM_ACK,
    input wire mfd_pkg::tx_req_t     O_TX,
    input wire mfd_pkg::tel_status_t I_TEL,
    input wire logic                 I_TIMER1_ZERO,
    input wire logic                 O_BUSY,
    input wire logic                 O_TABLE_DONE_IRQ,
    input wire logic                 O_FRAME_FETCHED_IRQ,
    input wire logic                 O_REPLY_CHECKED_IRQ
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);
    logic       en_ok;
    logic [8:0] gap;

    // Codes 2 and 3 share the upper loopback bit
    always_ff @(posedge I_MCLK or negedge I_RST_B)
        if (!I_RST_B)
            en_ok <= 1'b0;
        else if (I_WR && I_ADDR == mfd_pkg::SYS_CTRL_OFS)
            en_ok <= I_WDATA[0] && I_WDATA[2];

    always_ff @(posedge I_MCLK or negedge I_RST_B)
        if (!I_RST_B)
            gap <= 9'h1FF;
        else if (I_TEL.done)
            gap <= 9'h000;
        else if (gap != 9'h1FF)
            gap <= gap + 9'h001;

    a_fetch_needs_en: assert property (O_MEM.rd |-> $past(en_ok)) else $error("Fetch while disabled");
    a_gap_kept: assert property (O_MEM.rd |-> gap >= mfd_pkg::GAP_CYC - 9'h004) else $error("Spacing short");
    a_fetch_idle: assert property (O_MEM.rd |-> !$past(O_BUSY)) else $error("Fetch while busy");
    a_ack_fetched: assert property (I_MEM_ACK |=> O_FRAME_FETCHED_IRQ) else $error("No fetched pulse");
    a_fetch_sends: assert property (O_FRAME_FETCHED_IRQ |=> O_TX.start) else $error("Fetched frame not sent");
    a_tx_busy: assert property (O_TX.start |=> O_BUSY) else $error("Busy low after start");
    a_busy_rise: assert property ($rose(O_BUSY) |-> O_MEM.rd || O_TX.start || $past(O_TX.start))
        else $error("Busy rose alone");
    a_done_idle: assert property (I_TEL.done |=> !O_BUSY) else $error("Busy after telegram");
    a_reply_ok: assert property (I_TEL.done && !I_TEL.timeout |=> O_REPLY_CHECKED_IRQ)
        else $error("No reply pulse");
    a_reply_cause: assert property (O_REPLY_CHECKED_IRQ |-> $past(I_TEL.done) && !$past(I_TEL.timeout))
        else $error("Reply pulse without reply");
    a_done_cause: assert property (O_TABLE_DONE_IRQ |-> O_FRAME_FETCHED_IRQ || $past(I_TIMER1_ZERO))
        else $error("Table done without cause");
    c_table_done: cover property (O_TABLE_DONE_IRQ);
    c_reply: cover property (O_REPLY_CHECKED_IRQ);
    c_timeout: cover property (I_TEL.done && I_TEL.timeout);
endmodule

bind master_frame_dispatcher mfd_props u_props (.I_MCLK, .I_RST_B, .I_ADDR, .I_WDATA, .I_WR, .O_MEM,
    .I_MEM_ACK, .O_TX, .I_TEL, .I_TIMER1_ZERO, .O_BUSY, .O_TABLE_DONE_IRQ, .O_FRAME_FETCHED_IRQ,
    .O_REPLY_CHECKED_IRQ);

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic                 mclk = 1'b0, rst_b = 1'b0, sync_b = 1'b1;
    logic [7:0]           addr = 8'h00;
    logic [31:0]          wdata = 32'h0;
    logic                 wr_s = 1'b0, rd_s = 1'b0, tz = 1'b0, slow = 1'b0, tmo = 1'b0;
    logic [31:0]          rdata;
    logic                 ack, busy, tdi, ffi, rci;
    logic [15:0]          mdata;
    mfd_pkg::mem_req_t    mem;
    mfd_pkg::tx_req_t     tx;
    mfd_pkg::tel_status_t tel;
    int                   mismatches = 0, num_checks = 0, n_td = 0, n_rc = 0, n_ff = 0;
    localparam logic [7:0] mode_ofs = mfd_pkg::MODE_OFS;
    logic [15:0]          fq[$];

    always #5 mclk = ~mclk;

    master_frame_dispatcher dut (.I_MCLK(mclk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .O_MEM(mem), .I_MEM_ACK(ack), .I_MEM_DATA(mdata),
        .O_TX(tx), .I_TEL(tel), .I_TIMER1_ZERO(tz), .I_EXT_SYNC_B(sync_b), .O_BUSY(busy),
        .O_TABLE_DONE_IRQ(tdi), .O_FRAME_FETCHED_IRQ(ffi), .O_REPLY_CHECKED_IRQ(rci));
    mfd_far_model far (.i_clk(mclk), .i_rst_b(rst_b), .i_mem(mem), .o_ack(ack), .o_data(mdata),
        .i_tx(tx), .o_tel(tel), .i_slow(slow), .i_tmo(tmo));

    always @(posedge mclk)
    begin
        if (tx.start === 1'b1)
            fq.push_back(tx.frame);
        n_td += int'(tdi === 1'b1);
        n_rc += int'(rci === 1'b1);
        n_ff += int'(ffi === 1'b1);
    end

    function automatic logic [31:0] mv(input logic [15:0] a);
        return {16'h0000, a ^ 16'h5A5A};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1 chk(name, rdata, exp);
    endtask

    task automatic pulse_tz();
        @(posedge mclk);
        tz <= 1'b1;
        @(posedge mclk);
        tz <= 1'b0;
    endtask

    // Quiet for longer than one frame spacing
    task automatic settle();
        int q = 0, t;
        for (t = 0; t < 20000 && q < 600; t++)
        begin
            @(posedge mclk);
            q = (busy === 1'b0 && mem.rd === 1'b0) ? q + 1 : 0;
        end
        if (q < 600)
            mismatches++;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #600_000;
        mismatches++;
        stop_test();
    end

    initial
    begin
        int t, td;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        rd(mode_ofs, 32'h0, "mode_reset");
        rd(8'h20, 32'h0, "unmapped");
        wr(mode_ofs, 32'h1);
        repeat (50) @(posedge mclk);
        wr(mfd_pkg::SYS_CTRL_OFS, 32'h3);
        repeat (50) @(posedge mclk);
        chk("held", fq.size(), 0);
        wr(mfd_pkg::SYS_CTRL_OFS, 32'h7);
        settle();
        chk("resumed", fq.size(), 1);
        chk("slot", fq[0], mv(mfd_pkg::FRAME_SLOT_ADDR));
        chk("reply", n_rc, 1);
        tmo <= 1'b1;
        wr(mode_ofs, 32'h1);
        settle();
        tmo <= 1'b0;
        chk("tmo_sent", fq.size(), 2);
        chk("tmo_reply", n_rc, 1);
        fq.delete();
        slow <= 1'b1;
        wr(mfd_pkg::PTR_OFS, 32'h40);
        wr(mode_ofs, 32'h32);
        settle();
        slow <= 1'b0;
        chk("auto_n", fq.size(), 3);
        chk("auto_last", fq[2], mv(16'h0044));
        chk("auto_done", n_td, 1);
        chk("fetched", n_ff, 5);
        fq.delete();
        wr(mfd_pkg::PTR_OFS, 32'h80);
        wr(mode_ofs, 32'h23);
        settle();
        chk("mix_n", fq.size(), 3);
        chk("mix_first", fq[0], mv(16'h0080));
        chk("mix_last", fq[2], mv(mfd_pkg::FRAME_SLOT_ADDR));
        fq.delete();
        wr(mfd_pkg::PTR_OFS, 32'h100);
        wr(mode_ofs, 32'h14);
        wr(mfd_pkg::NEXT_PTR_OFS, 32'h200);
        wr(mfd_pkg::NEXT_MODE_OFS, 32'h8);
        repeat (100) @(posedge mclk);
        chk("timed_wait", fq.size(), 0);
        pulse_tz();
        settle();
        chk("timed_frame", fq[0], mv(16'h0100));
        rd(mode_ofs, 32'h8, "adv_mode");
        rd(mfd_pkg::PTR_OFS, 32'h200, "adv_ptr");
        rd(mfd_pkg::NEXT_MODE_OFS, 32'h0, "adv_clear");
        td = n_td;
        pulse_tz();
        repeat (5) @(posedge mclk);
        chk("empty_done", n_td, td + 1);
        chk("empty_none", fq.size(), 1);
        fq.delete();
        wr(mfd_pkg::PTR_OFS, 32'h300);
        wr(mode_ofs, 32'h2);
        settle();
        chk("full_n", fq.size(), 32);
        fq.delete();
        wr(mode_ofs, 32'h52);
        for (t = 0; t < 2000 && fq.size() == 0; t++)
            @(posedge mclk);
        rd(mode_ofs, 32'h0002_0050, "busy_on");
        wr(mode_ofs, 32'h1_0000);
        settle();
        chk("auto_cancel", fq.size(), 1);
        fq.delete();
        td = n_td;
        wr(mode_ofs, 32'h14);
        wr(mode_ofs, 32'h1_0000);
        wr(mode_ofs, 32'h8);
        wr(mode_ofs, 32'h1_0000);
        pulse_tz();
        wr(mfd_pkg::SYS_CTRL_OFS, 32'h0);
        wr(mode_ofs, 32'h1);
        wr(mode_ofs, 32'h1_0000);
        wr(mfd_pkg::SYS_CTRL_OFS, 32'h5);
        settle();
        chk("cancel_none", fq.size(), 0);
        chk("cancel_td", n_td, td);
        wr(mfd_pkg::SYS_CTRL_OFS, 32'hF);
        wr(mfd_pkg::PTR_OFS, 32'h40);
        wr(mode_ofs, 32'h14);
        @(posedge mclk);
        sync_b <= 1'b0;
        repeat (4) @(posedge mclk);
        sync_b <= 1'b1;
        settle();
        chk("ext_sync", fq.size(), 1);
        stop_test();
    end
endmodule
